//--- rtl/wdit_top.sv
// AXI4-Lite watchdog interval timer with chip reset request
`timescale 1ns/100ps
module wdit_top
   import wdit_pkg::*;
#(
   parameter int UNIT_CYCLES = WDIT_UNIT_CYC
)
(
   input  wire logic        aclk,
   input  wire logic        aresetn,
   input  wire logic [11:0] s_axi_awaddr,
   input  wire logic        s_axi_awvalid,
   output logic             s_axi_awready,
   input  wire logic [31:0] s_axi_wdata,
   input  wire logic [3:0]  s_axi_wstrb,
   input  wire logic        s_axi_wvalid,
   output logic             s_axi_wready,
   output logic [1:0]       s_axi_bresp,
   output logic             s_axi_bvalid,
   input  wire logic        s_axi_bready,
   input  wire logic [11:0] s_axi_araddr,
   input  wire logic        s_axi_arvalid,
   output logic             s_axi_arready,
   output logic [31:0]      s_axi_rdata,
   output logic [1:0]       s_axi_rresp,
   output logic             s_axi_rvalid,
   input  wire logic        s_axi_rready,
   input  wire logic        mode2_detect,
   output logic             display_channel_mode2_flag,
   output logic             chip_reset
);
   import wdit_pkg::*;

   logic [7:0]  ctrl_reg;
   logic        restart_reg;
   logic        fclr_reg;
   logic        aw_hold_reg;
   logic        w_hold_reg;
   logic [11:0] awaddr_reg;
   logic [31:0] wdata_reg;
   logic [3:0]  wstrb_reg;
   logic        bvalid_reg;
   logic [1:0]  bresp_reg;
   logic        rvalid_reg;
   logic [31:0] rdata_reg;
   logic [1:0]  rresp_reg;
   logic        flag_reg;
   logic [7:0]  rst_cnt_reg;
   logic        chip_reset_reg;
   logic        awready_reg;
   logic        wready_reg;
   logic        arready_reg;
   wire         aw_take;
   wire         w_take;
   wire         do_write;
   wire         ctrl_hit;
   wire         ar_take;
   wire         overflow;
   wire  [7:0]  wbyte;
   wire         aw_hold_next;
   wire         w_hold_next;
   wire         bvalid_next;
   wire         rvalid_next;

   assign aw_take  = s_axi_awvalid && !aw_hold_reg && !bvalid_reg;
   assign w_take   = s_axi_wvalid && !w_hold_reg && !bvalid_reg;
   assign do_write = aw_hold_reg && w_hold_reg && !bvalid_reg;
   assign ctrl_hit = (awaddr_reg == WDIT_CTRL_ADDR) && wstrb_reg[0];
   assign wbyte    = wdata_reg[7:0];
   assign ar_take  = s_axi_arvalid && !rvalid_reg;

   // Next states of the hold and answer flags, for the registered readies
   assign aw_hold_next = aw_take || (aw_hold_reg && !do_write);
   assign w_hold_next  = w_take || (w_hold_reg && !do_write);
   assign bvalid_next  = do_write || (bvalid_reg && !s_axi_bready);
   assign rvalid_next  = ar_take || (rvalid_reg && !s_axi_rready);

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         aw_hold_reg <= 1'b0;
         w_hold_reg  <= 1'b0;
         awaddr_reg  <= '0;
         wdata_reg   <= '0;
         wstrb_reg   <= '0;
      end
      else
      begin
         if (aw_take)
         begin
            aw_hold_reg <= 1'b1;
            awaddr_reg  <= s_axi_awaddr;
         end
         else if (do_write)
            aw_hold_reg <= 1'b0;
         if (w_take)
         begin
            w_hold_reg <= 1'b1;
            wdata_reg  <= s_axi_wdata;
            wstrb_reg  <= s_axi_wstrb;
         end
         else if (do_write)
            w_hold_reg <= 1'b0;
      end
   end

   // Control register; pulses last one cycle per accepted write
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         ctrl_reg    <= WDIT_CTRL_RESET;
         restart_reg <= 1'b0;
         fclr_reg    <= 1'b0;
      end
      else
      begin
         restart_reg <= do_write && ctrl_hit && wbyte[WDIT_RESTART_BIT];
         fclr_reg    <= do_write && ctrl_hit && wbyte[WDIT_FCLR_BIT];
         if (do_write && ctrl_hit)
            ctrl_reg <= wbyte & ~(8'h01 << WDIT_RESTART_BIT)
                              & ~(8'h01 << WDIT_FCLR_BIT);
      end
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         bvalid_reg <= 1'b0;
         bresp_reg  <= WDIT_RESP_OKAY;
      end
      else if (do_write)
      begin
         bvalid_reg <= 1'b1;
         bresp_reg  <= (awaddr_reg == WDIT_CTRL_ADDR) ? WDIT_RESP_OKAY
                                                      : WDIT_RESP_SLVERR;
      end
      else if (s_axi_bready)
         bvalid_reg <= 1'b0;
   end

   // Control is write-only; only the status word is readable
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rvalid_reg <= 1'b0;
         rdata_reg  <= '0;
         rresp_reg  <= WDIT_RESP_OKAY;
      end
      else if (ar_take)
      begin
         rvalid_reg <= 1'b1;
         if (s_axi_araddr == WDIT_STATUS_ADDR)
         begin
            rdata_reg <= {30'h0, chip_reset_reg, flag_reg};
            rresp_reg <= WDIT_RESP_OKAY;
         end
         else
         begin
            rdata_reg <= '0;
            rresp_reg <= WDIT_RESP_SLVERR;
         end
      end
      else if (s_axi_rready)
         rvalid_reg <= 1'b0;
   end

   // Set wins over clear so a detection is never lost
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         flag_reg <= 1'b0;
      else if (mode2_detect)
         flag_reg <= 1'b1;
      else if (fclr_reg)
         flag_reg <= 1'b0;
   end

   // Stretched pulse so the whole chip sees the reset
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         rst_cnt_reg    <= '0;
         chip_reset_reg <= 1'b0;
      end
      else if (overflow)
      begin
         rst_cnt_reg    <= WDIT_RST_PULSE;
         chip_reset_reg <= 1'b1;
      end
      else if (rst_cnt_reg != '0)
      begin
         rst_cnt_reg    <= rst_cnt_reg - 8'h01;
         chip_reset_reg <= (rst_cnt_reg != 8'h01);
      end
   end

   // Readies are flops so no bus output leans on a gate path
   always_ff @(posedge aclk)
   begin
      if (!aresetn)
      begin
         awready_reg <= 1'b1;
         wready_reg  <= 1'b1;
         arready_reg <= 1'b1;
      end
      else
      begin
         awready_reg <= !aw_hold_next && !bvalid_next;
         wready_reg  <= !w_hold_next && !bvalid_next;
         arready_reg <= !rvalid_next;
      end
   end

   wdit_core #(
      .UNIT_CYCLES (UNIT_CYCLES)
   ) u_core (
      .aclk                  (aclk),
      .aresetn               (aresetn),
      .enable                (ctrl_reg[WDIT_EN_BIT]),
      .restart               (restart_reg),
      .interval_select_field (ctrl_reg[WDIT_SEL_LSB +: WDIT_SEL_W]),
      .overflow              (overflow)
   );

   assign s_axi_awready = awready_reg;
   assign s_axi_wready  = wready_reg;
   assign s_axi_bvalid  = bvalid_reg;
   assign s_axi_bresp   = bresp_reg;
   assign s_axi_arready = arready_reg;
   assign s_axi_rvalid  = rvalid_reg;
   assign s_axi_rdata   = rdata_reg;
   assign s_axi_rresp   = rresp_reg;
   assign display_channel_mode2_flag = flag_reg;
   assign chip_reset    = chip_reset_reg;
endmodule

//--- rtl/wdit_pkg.sv
// Constants and register map of the watchdog interval timer
// Notes on behaviour
// - Counter runs toward overflow only while the enable bit is set.
// - Writing one to restart clears the counter; full interval again.
// - Writing one to mode-flag clear clears the display mode-2 flag.
// - Interval select zero gives eight quarter-second units, two seconds.
// - Interval select N from 1 to 7 gives N quarter-second units.
// - Reaching the selected interval asserts the internal chip reset.
// - After reset the watchdog stays disabled until software enables it.
package wdit_pkg;
   localparam logic [11:0] WDIT_CTRL_ADDR   = 12'h080;
   localparam logic [11:0] WDIT_STATUS_ADDR = 12'h084;
   localparam int          WDIT_EN_BIT      = 7;
   localparam int          WDIT_RESTART_BIT = 6;
   localparam int          WDIT_FCLR_BIT    = 5;
   localparam int          WDIT_DIV_BIT     = 4;
   localparam int          WDIT_SEL_LSB     = 0;
   localparam int          WDIT_SEL_W       = 3;
   localparam logic [7:0]  WDIT_CTRL_RESET  = 8'h00;
   localparam logic [1:0]  WDIT_RESP_OKAY   = 2'h0;
   localparam logic [1:0]  WDIT_RESP_SLVERR = 2'h2;
   localparam int          WDIT_CLK_HZ      = 100000000;
   localparam int          WDIT_UNIT_MS     = 250;
   localparam int          WDIT_UNIT_CYC    = WDIT_CLK_HZ / 1000 * WDIT_UNIT_MS;
   localparam logic [3:0]  WDIT_UNITS_ZERO  = 4'h8;
   localparam logic [7:0]  WDIT_RST_PULSE   = 8'h10;
endpackage

//--- rtl/wdit_core.sv
// Watchdog counting core: quarter-second prescaler and unit counter
`timescale 1ns/100ps
module wdit_core
   import wdit_pkg::*;
#(
   parameter int UNIT_CYCLES = WDIT_UNIT_CYC
)
(
   input  wire logic                  aclk,
   input  wire logic                  aresetn,
   input  wire logic                  enable,
   input  wire logic                  restart,
   input  wire logic [WDIT_SEL_W-1:0] interval_select_field,
   output logic                       overflow
);
   import wdit_pkg::*;

   logic [27:0] pre_reg;
   logic [3:0]  units_reg;
   logic        overflow_reg;
   wire  [3:0]  target;
   wire         tick;
   wire         hit;

   assign target = (interval_select_field == '0) ? WDIT_UNITS_ZERO
                 : {1'b0, interval_select_field};
   assign tick = (pre_reg == 28'(UNIT_CYCLES - 1));
   assign hit  = enable && tick && ((units_reg + 4'h1) >= target);
   assign overflow = overflow_reg;

   always_ff @(posedge aclk)
   begin
      if (!aresetn || !enable || restart || hit)
      begin
         pre_reg   <= '0;
         units_reg <= '0;
      end
      else if (tick)
      begin
         pre_reg   <= '0;
         units_reg <= units_reg + 4'h1;
      end
      else
         pre_reg <= pre_reg + 28'h1;
   end

   always_ff @(posedge aclk)
   begin
      if (!aresetn)
         overflow_reg <= 1'b0;
      else
         overflow_reg <= hit && !restart;
   end
endmodule

//--- bench/wdit_checker.sv
// Port assertions for the watchdog interval timer
`timescale 1ns/100ps
module wdit_checker
(
   input wire logic aclk,
   input wire logic aresetn,
   input wire logic s_axi_awvalid,
   input wire logic s_axi_awready,
   input wire logic s_axi_wvalid,
   input wire logic s_axi_wready,
   input wire logic s_axi_bvalid,
   input wire logic s_axi_bready,
   input wire logic s_axi_arvalid,
   input wire logic s_axi_arready,
   input wire logic s_axi_rvalid,
   input wire logic s_axi_rready,
   input wire logic chip_reset
);
   logic wr_seen_reg;
   default clocking @(posedge aclk); endclocking
   default disable iff (!aresetn);
   // Any write arms it, so only the untouched state is proven quiet
   always_ff @(posedge aclk)
      wr_seen_reg <= aresetn && (wr_seen_reg || s_axi_awready && s_axi_awvalid);
   a_idle_quiet: assert property (!wr_seen_reg |-> !chip_reset)
      else $error("chip reset while never written");
   a_pulse_width: assert property ($rose(chip_reset) |-> chip_reset[*8]
      ##1 chip_reset[*8] ##1 !chip_reset) else $error("reset pulse width");
   a_b_stands: assert property (s_axi_bvalid && !s_axi_bready |=>
      s_axi_bvalid) else $error("bvalid dropped");
   a_r_stands: assert property (s_axi_rvalid && !s_axi_rready |=>
      s_axi_rvalid) else $error("rvalid dropped");
   a_w_refused: assert property (s_axi_bvalid |->
      !s_axi_awready && !s_axi_wready) else $error("write taken early");
   a_ar_refused: assert property (s_axi_rvalid |-> !s_axi_arready)
      else $error("read taken early");
   a_b_latency: assert property (s_axi_awvalid && s_axi_awready &&
      s_axi_wvalid && s_axi_wready |-> ##2 s_axi_bvalid)
      else $error("write answer late");
   a_r_latency: assert property (s_axi_arvalid && s_axi_arready |=>
      s_axi_rvalid) else $error("read answer late");
endmodule
bind wdit_top wdit_checker wdit_checker_inst (.*);

//--- bench/wdit_tb_top.sv
// Self-checking bench for the watchdog interval timer
`timescale 1ns/100ps
module wdit_tb_top;
   import wdit_pkg::*;
   localparam int U = 10;
   logic        aclk, aresetn, mode2_detect, display_channel_mode2_flag;
   logic        s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
   logic        s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready;
   logic        s_axi_rvalid, s_axi_rready, chip_reset, ta, tw, tr, tb;
   logic [11:0] s_axi_awaddr, s_axi_araddr;
   logic [31:0] s_axi_wdata, s_axi_rdata, rdat;
   logic [3:0]  s_axi_wstrb;
   logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
   logic [15:0] lfsr = 16'h0043;
   logic [2:0]  sel;
   int          mismatches = 0, n_tests = 0, cnt;
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin \
   $display("ERROR %s expected %0h seen %0h", nm, e, g); mismatches++; end end
   wdit_top #(.UNIT_CYCLES(U)) wdit_top_inst (.*);
   initial
   begin
      aclk = 1'b0;
      forever #5 aclk = ~aclk;
   end
   function automatic logic [15:0] lfsr_step(input logic [15:0] v);
      return {v[14:0], v[15] ^ v[13] ^ v[12] ^ v[10]};
   endfunction
   function automatic int ivl(input logic [2:0] s);
      return (s == 3'h0 ? 8 : int'(s)) * U;
   endfunction
   task automatic results();
      $display("comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask
   // Write if w is set, else read; top two data bytes are random filler, byte 1 is 5A
   task automatic xfer(input logic w, input logic [11:0] a,
                       input logic [7:0] d);
      @(posedge aclk);
      lfsr = lfsr_step(lfsr);
      {s_axi_awaddr, s_axi_araddr, s_axi_wdata} <= {a, a, lfsr, 8'h5A, d};
      {s_axi_awvalid, s_axi_wvalid, s_axi_bready} <= {3{w}};
      {s_axi_arvalid, s_axi_rready} <= {2{!w}};
      repeat (50)
      begin
         @(negedge aclk);
         {ta, tw, tr} = {s_axi_awready, s_axi_wready, s_axi_arready};
         tb = w ? s_axi_bvalid : s_axi_rvalid;
         resp = w ? s_axi_bresp : s_axi_rresp;
         rdat = s_axi_rdata;
         @(posedge aclk);
         if (ta) s_axi_awvalid <= 1'b0;
         if (tw) s_axi_wvalid <= 1'b0;
         if (tr) s_axi_arvalid <= 1'b0;
         if (tb)
         begin
            {s_axi_bready, s_axi_rready} <= 2'b00;
            return;
         end
      end
      mismatches++;
      results();
   endtask
   // With must set, a reset that never comes ends the run as a failure
   task automatic wait_reset(input logic must);
      for (cnt = 0; chip_reset !== 1'b1 && cnt < 200; cnt++) @(negedge aclk);
      if (must && cnt >= 200)
      begin
         mismatches++;
         results();
      end
   endtask
   initial
   begin
      {aresetn, mode2_detect, s_axi_awvalid, s_axi_wvalid, s_axi_bready} = '0;
      {s_axi_arvalid, s_axi_rready, s_axi_awaddr, s_axi_araddr} = '0;
      s_axi_wdata = '0;
      s_axi_wstrb = 4'hF;
      repeat (10) @(posedge aclk);
      aresetn <= 1'b1;
      wait_reset(1'b0);
      `CHK("idle", 1'b0, chip_reset)
      xfer(1'b0, WDIT_STATUS_ADDR, 8'h00);
      `CHK("status resp", WDIT_RESP_OKAY, resp)
      mode2_detect <= 1'b1;
      xfer(1'b0, WDIT_STATUS_ADDR, 8'h00);
      `CHK("flag set", 32'h1, rdat)
      // Clear while the detector still fires: the set must win
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h20);
      `CHK("ctrl resp", WDIT_RESP_OKAY, resp)
      @(negedge aclk);
      `CHK("flag held", 1'b1, display_channel_mode2_flag)
      @(posedge aclk);
      mode2_detect <= 1'b0;
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h20);
      xfer(1'b0, WDIT_STATUS_ADDR, 8'h00);
      `CHK("flag clear", 32'h0, rdat)
      @(negedge aclk);
      `CHK("flag pin", 1'b0, display_channel_mode2_flag)
      $display("flag test done");
      sel = lfsr[2:0];
      repeat (8)
      begin
         sel++;
         xfer(1'b1, WDIT_CTRL_ADDR, {5'h10, sel});
         wait_reset(1'b1);
         `CHK("interval", 1'b1, cnt > ivl(sel) - 3 && cnt < ivl(sel) + 5)
         xfer(1'b1, WDIT_CTRL_ADDR, 8'h00);
         repeat (20) @(posedge aclk);
      end
      $display("interval test done");
      sel = 3'h2;
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h82);
      repeat (4)
      begin
         repeat (8) @(posedge aclk);
         xfer(1'b1, WDIT_CTRL_ADDR, 8'hC2);
         `CHK("restart", 1'b0, chip_reset)
      end
      wait_reset(1'b1);
      `CHK("rearm", 1'b1, cnt > ivl(sel) - 3 && cnt < ivl(sel) + 5)
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h00);
      repeat (20) @(posedge aclk);
      $display("restart test done");
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h81);
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h01);
      // Byte 0 not strobed: answered, but the control byte stays put
      s_axi_wstrb <= 4'hE;
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h81);
      `CHK("no strobe", WDIT_RESP_OKAY, resp)
      s_axi_wstrb <= 4'hF;
      xfer(1'b1, 12'h100, 8'h81);
      `CHK("unmapped", WDIT_RESP_SLVERR, resp)
      wait_reset(1'b0);
      `CHK("disabled", 1'b0, chip_reset)
      xfer(1'b0, WDIT_CTRL_ADDR, 8'h00);
      `CHK("wo resp", WDIT_RESP_SLVERR, resp)
      `CHK("wo data", 32'h0, rdat)
      $display("access test done");
      // Reset in mid-run must leave the watchdog disabled again
      xfer(1'b1, WDIT_CTRL_ADDR, 8'h81);
      aresetn <= 1'b0;
      repeat (2) @(posedge aclk);
      aresetn <= 1'b1;
      wait_reset(1'b0);
      `CHK("reset off", 1'b0, chip_reset)
      $display("reset test done");
      results();
   end
endmodule
